/* cfim_props.sv */
// concurrent checks on the charger event mask block ports
`timescale 1ns/1ps
module cfim_props import mask_pkg::*; #(
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES,
  parameter int GAP_CYCLES   = INT_GAP_CYCLES
) (
  // clock, reset, controls
  input wire logic       CLK_SYS, RST, CE, WDOG_EXPIRE, REG_RESET_CMD, REG_WR, REG_RD,
  // register port
  input wire logic [7:0] REG_ADDR, REG_RDATA,
  // events and results
  input wire logic       OTG_LOW_BATTERY_EVT, THERMISTOR_COLD_EVT, THERMISTOR_COOL_EVT, THERMISTOR_WARM_EVT,
  input wire logic       THERMISTOR_HOT_EVT, CHARGE_CURRENT_REG_EVT, INPUT_BUS_OV_EVT, BATTERY_OV_EVT,
  input wire logic       INPUT_BUS_OC_EVT, BATTERY_OC_EVT, CONVERTER_OC_EVT, SECOND_SOURCE_OV_EVT, FIRST_SOURCE_OV_EVT,
  input wire logic [4:0] THERMAL_OTG_EVENT_SEEN, THERMAL_OTG_MASK_OUT,
  input wire logic [7:0] FAULT_EVENT_SEEN, FAULT_MASK_OUT,
  input wire logic       INT_N
);
  // events packed in the order of the seen outputs
  wire logic [12:0] evts = {OTG_LOW_BATTERY_EVT, THERMISTOR_COLD_EVT, THERMISTOR_COOL_EVT, THERMISTOR_WARM_EVT,
    THERMISTOR_HOT_EVT, CHARGE_CURRENT_REG_EVT, INPUT_BUS_OV_EVT, BATTERY_OV_EVT, INPUT_BUS_OC_EVT,
    BATTERY_OC_EVT, CONVERTER_OC_EVT, SECOND_SOURCE_OV_EVT, FIRST_SOURCE_OV_EVT};
  wire logic        live = |(evts & ~{THERMAL_OTG_MASK_OUT, FAULT_MASK_OUT});
  wire logic        mapped = REG_ADDR == THERMAL_OTG_EVENT_MASK_ADDR || REG_ADDR == FAULT_EVENT_MASK_LOW_ADDR;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // bound of 9 covers a merge behind a running pulse and gap of 3 each
  chk_unmasked_int: assert property (CE && live |=> ##[0:9] !INT_N) else $error("no pulse");
  // shape assumes the bench's pulse and gap of 3
  chk_pulse_shape: assert property ($fell(INT_N) |-> !INT_N[*3] ##1 INT_N[*3]) else $error("bad pulse");
  chk_seen_record: assert property (CE |=> {THERMAL_OTG_EVENT_SEEN, FAULT_EVENT_SEEN} == $past(evts))
    else $error("seen wrong");
  chk_wdog_clear: assert property (CE && WDOG_EXPIRE |=> THERMAL_OTG_MASK_OUT == 5'h00) else $error("wd");
  chk_wdog_keeps: assert property (CE && WDOG_EXPIRE && !REG_RESET_CMD && !REG_WR |=> $stable(FAULT_MASK_OUT))
    else $error("wd fault");
  chk_cmd_clear: assert property (CE && REG_RESET_CMD |=> FAULT_MASK_OUT == 8'h00 && THERMAL_OTG_MASK_OUT == 5'h00)
    else $error("cmd");
  chk_upper_zero: assert property (CE && REG_RD && REG_ADDR == THERMAL_OTG_EVENT_MASK_ADDR |=> REG_RDATA[7:5] == 3'h0)
    else $error("upper bits");
  chk_unmapped_read: assert property (CE && REG_RD && !mapped |=> REG_RDATA == UNMAPPED_READ_VALUE)
    else $error("unmapped");
endmodule
bind charger_fault_interrupt_masks cfim_props #(.PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_props (.*);

/* charger_fault_interrupt_masks.sv */
`timescale 1ns/1ps
// What this block does
// RQ1 - low battery for otg interrupts unless bit4 masked
// RQ2 - cold crossing interrupts unless bit3 masked
// RQ3 - cool crossing interrupts unless bit2 masked
// RQ4 - warm crossing interrupts unless bit1 masked
// RQ5 - hot crossing interrupts unless bit0 masked
// RQ6 - thermal/otg masks cleared by reset, watchdog, command
// RQ7 - fault masks cleared by reset and command only
// RQ8 - charge current regulation change unless bit7 masked
// RQ9 - input bus overvoltage unless bit6 masked
// RQ10 - battery overvoltage unless bit5 masked
// RQ11 - input bus overcurrent unless bit4 masked
// RQ12 - battery overcurrent unless bit3 masked
// RQ13 - converter overcurrent unless bit2 masked
// RQ14 - second source overvoltage unless bit1 masked
// RQ15 - first source overvoltage unless bit0 masked
// RQ16 - interrupt pin gives pulses, not levels
// RQ17 - masks gate interrupts only, flags unaffected
// RQ18 - upper three bits read zero, writes ignored
module charger_fault_interrupt_masks import mask_pkg::*; #(
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES,
  parameter int GAP_CYCLES   = INT_GAP_CYCLES
) (
  // clock, reset, enable
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CE,
  // reset sources besides power-on
  input  wire logic       WDOG_EXPIRE,
  input  wire logic       REG_RESET_CMD,
  // register port from the serial control engine
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // event pulses from the detectors
  input  wire logic       OTG_LOW_BATTERY_EVT,
  input  wire logic       THERMISTOR_COLD_EVT,
  input  wire logic       THERMISTOR_COOL_EVT,
  input  wire logic       THERMISTOR_WARM_EVT,
  input  wire logic       THERMISTOR_HOT_EVT,
  input  wire logic       CHARGE_CURRENT_REG_EVT,
  input  wire logic       INPUT_BUS_OV_EVT,
  input  wire logic       BATTERY_OV_EVT,
  input  wire logic       INPUT_BUS_OC_EVT,
  input  wire logic       BATTERY_OC_EVT,
  input  wire logic       CONVERTER_OC_EVT,
  input  wire logic       SECOND_SOURCE_OV_EVT,
  input  wire logic       FIRST_SOURCE_OV_EVT,
  // raw event record, mask values and interrupt pin
  output logic      [4:0] THERMAL_OTG_EVENT_SEEN,
  output logic      [7:0] FAULT_EVENT_SEEN,
  output logic      [4:0] THERMAL_OTG_MASK_OUT,
  output logic      [7:0] FAULT_MASK_OUT,
  output logic            INT_N
);
  logic [4:0] thermal_otg_event_mask;
  logic [7:0] fault_event_mask_low;
  logic [4:0] thermal_events;
  logic [7:0] fault_events;
  logic [4:0] thermal_raise;
  logic [7:0] fault_raise;
  logic       any_raise;
  logic       wr_thermal;
  logic       wr_fault;
  logic [7:0] next_rdata;
  logic [7:0] thermal_read;

  // gather the event pulses into register-shaped vectors
  assign thermal_events[OTG_LOW_BATTERY_BIT] = OTG_LOW_BATTERY_EVT;
  assign thermal_events[THERMISTOR_COLD_BIT] = THERMISTOR_COLD_EVT;
  assign thermal_events[THERMISTOR_COOL_BIT] = THERMISTOR_COOL_EVT;
  assign thermal_events[THERMISTOR_WARM_BIT] = THERMISTOR_WARM_EVT;
  assign thermal_events[THERMISTOR_HOT_BIT]  = THERMISTOR_HOT_EVT;
  assign fault_events[CHARGE_CURRENT_REG_BIT] = CHARGE_CURRENT_REG_EVT;
  assign fault_events[INPUT_BUS_OV_BIT]       = INPUT_BUS_OV_EVT;
  assign fault_events[BATTERY_OV_BIT]         = BATTERY_OV_EVT;
  assign fault_events[INPUT_BUS_OC_BIT]       = INPUT_BUS_OC_EVT;
  assign fault_events[BATTERY_OC_BIT]         = BATTERY_OC_EVT;
  assign fault_events[CONVERTER_OC_BIT]       = CONVERTER_OC_EVT;
  assign fault_events[SECOND_SOURCE_OV_BIT]   = SECOND_SOURCE_OV_EVT;
  assign fault_events[FIRST_SOURCE_OV_BIT]    = FIRST_SOURCE_OV_EVT;

  // a mask bit at one blocks its event; zero lets it through
  assign thermal_raise = thermal_events & ~thermal_otg_event_mask; // RQ1 RQ2 RQ3 RQ4 RQ5
  assign fault_raise   = fault_events & ~fault_event_mask_low; // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14 RQ15
  assign any_raise     = (|thermal_raise) | (|fault_raise);

  // register decode
  assign wr_thermal   = REG_WR && (REG_ADDR == THERMAL_OTG_EVENT_MASK_ADDR);
  assign wr_fault     = REG_WR && (REG_ADDR == FAULT_EVENT_MASK_LOW_ADDR);
  assign thermal_read = {3'h0, thermal_otg_event_mask}; // RQ18
  assign next_rdata   = (REG_ADDR == THERMAL_OTG_EVENT_MASK_ADDR) ? thermal_read :
                        (REG_ADDR == FAULT_EVENT_MASK_LOW_ADDR)   ? fault_event_mask_low :
                        UNMAPPED_READ_VALUE;

  // thermistor/otg masks: watchdog and reset command both clear, and beat a write
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      thermal_otg_event_mask <= THERMAL_OTG_EVENT_MASK_RST[4:0];
    end else if (CE) begin
      if (WDOG_EXPIRE || REG_RESET_CMD) begin
        thermal_otg_event_mask <= THERMAL_OTG_EVENT_MASK_RST[4:0]; // RQ6
      end else if (wr_thermal) begin
        thermal_otg_event_mask <= REG_WDATA[4:0] & THERMAL_OTG_WRITABLE[4:0]; // RQ18
      end
    end
  end

  // fault masks survive the watchdog so a host hang keeps its fault policy
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fault_event_mask_low <= FAULT_EVENT_MASK_LOW_RST;
    end else if (CE) begin
      if (REG_RESET_CMD) begin
        fault_event_mask_low <= FAULT_EVENT_MASK_LOW_RST; // RQ7
      end else if (wr_fault) begin
        fault_event_mask_low <= REG_WDATA;
      end
    end
  end

  // read data and raw event record; the record ignores the masks
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      REG_RDATA              <= 8'h00;
      THERMAL_OTG_EVENT_SEEN <= 5'h00;
      FAULT_EVENT_SEEN       <= 8'h00;
    end else if (CE) begin
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
      THERMAL_OTG_EVENT_SEEN <= thermal_events; // RQ17
      FAULT_EVENT_SEEN       <= fault_events; // RQ17
    end
  end

  assign THERMAL_OTG_MASK_OUT = thermal_otg_event_mask;
  assign FAULT_MASK_OUT       = fault_event_mask_low;

  // unmasked events of one cycle share one pulse; requests during a pulse or gap merge into one more pulse
  int_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES),
    .GAP_CYCLES   (GAP_CYCLES)
  ) u_pulse (
    .clk     (CLK_SYS),
    .rst     (RST),
    .ce      (CE),
    .request (any_raise),
    .int_n   (INT_N)
  );
endmodule

/* charger_fault_interrupt_masks_tb_top.sv */
// self-checking bench for the charger event mask block
`timescale 1ns/1ps
module charger_fault_interrupt_masks_tb_top import mask_pkg::*;;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wdog = 1'b0, cmd = 1'b0, wr, rd, int_n;
  logic [7:0]  addr, wdata, rdata, rv;
  logic [12:0] ev = '0, seen, mout;
  int          mismatches = 0, tests_run = 0, lows;
  always #5 clk = ~clk;
  charger_fault_interrupt_masks #(.PULSE_CYCLES(3), .GAP_CYCLES(3)) uut (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .WDOG_EXPIRE(wdog), .REG_RESET_CMD(cmd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .OTG_LOW_BATTERY_EVT(ev[12]),
    .THERMISTOR_COLD_EVT(ev[11]), .THERMISTOR_COOL_EVT(ev[10]), .THERMISTOR_WARM_EVT(ev[9]),
    .THERMISTOR_HOT_EVT(ev[8]), .CHARGE_CURRENT_REG_EVT(ev[7]), .INPUT_BUS_OV_EVT(ev[6]),
    .BATTERY_OV_EVT(ev[5]), .INPUT_BUS_OC_EVT(ev[4]), .BATTERY_OC_EVT(ev[3]), .CONVERTER_OC_EVT(ev[2]),
    .SECOND_SOURCE_OV_EVT(ev[1]), .FIRST_SOURCE_OV_EVT(ev[0]), .THERMAL_OTG_EVENT_SEEN(seen[12:8]),
    .FAULT_EVENT_SEEN(seen[7:0]), .THERMAL_OTG_MASK_OUT(mout[12:8]), .FAULT_MASK_OUT(mout[7:0]), .INT_N(int_n));
  host_port host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rv);
    chk(16'(rv), 16'(exp));
  endtask
  // fire events 0..n-1 one by one; an event pulses only where its bit of m is clear
  // a mixed pattern in m catches a mask bit wired to the wrong event
  task automatic sweep(input int n, input logic [12:0] m);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) ev[i] = 1'b1;
      @(negedge clk) ev[i] = 1'b0;
      chk(16'(seen), 16'(1) << i);
      lows = 0;
      repeat (12) begin
        if (int_n === 1'b0) lows++;
        @(negedge clk);
      end
      chk(16'(lows), m[i] ? 16'h0000 : 16'h0003);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang well past the expected run of about 800 cycles
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h00);
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'h00);
    rd_chk(8'h2D, 8'h00);
    host.wr_reg(THERMAL_OTG_EVENT_MASK_ADDR, 8'hFF);
    host.wr_reg(FAULT_EVENT_MASK_LOW_ADDR, 8'hFF);
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h1F);
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'hFF);
    sweep(13, 13'h1FFF);
    $display("test masked_events done");
    // watchdog held across a write to the thermal/otg register must still win
    @(negedge clk) wdog = 1'b1;
    host.wr_reg(THERMAL_OTG_EVENT_MASK_ADDR, 8'h1F);
    wdog = 1'b0;
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h00);
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'hFF);
    sweep(13, 13'h00FF);
    $display("test watchdog done");
    // mixed patterns, upper bits of 2B and a write to an unmapped offset ignored
    host.wr_reg(THERMAL_OTG_EVENT_MASK_ADDR, 8'hEA);
    host.wr_reg(FAULT_EVENT_MASK_LOW_ADDR, 8'hA5);
    host.wr_reg(8'h2D, 8'hFF);
    chk(16'(mout), 16'h0AA5);
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h0A);
    sweep(13, 13'h0AA5);
    $display("test bit_mapping done");
    // a write while the clock enable is low must not land
    @(negedge clk) ce = 1'b0;
    host.wr_reg(FAULT_EVENT_MASK_LOW_ADDR, 8'h00);
    @(negedge clk) ce = 1'b1;
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'hA5);
    $display("test clock_enable done");
    @(negedge clk) cmd = 1'b1;
    @(negedge clk) cmd = 1'b0;
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h00);
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'h00);
    sweep(13, 13'h0000);
    $display("test reset_command done");
    // a second reset in mid-run clears what the host wrote
    host.wr_reg(FAULT_EVENT_MASK_LOW_ADDR, 8'h3C);
    host.wr_reg(THERMAL_OTG_EVENT_MASK_ADDR, 8'h15);
    @(negedge clk) rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    rd_chk(FAULT_EVENT_MASK_LOW_ADDR, 8'h00);
    rd_chk(THERMAL_OTG_EVENT_MASK_ADDR, 8'h00);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule

/* host_port.sv */
// register port master standing in for the serial control engine
`timescale 1ns/1ps
module host_port (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    {addr, wdata, wr, rd} = '0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk) {addr, wdata, wr} = {~a, ~d, 1'b0};
  endtask
  // read data is registered, so it is taken one edge after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {addr, rd} = {a, 1'b1};
    @(negedge clk) {addr, rd} = {~a, 1'b0};
    d = rdata;
  endtask
endmodule

/* int_pulse_gen.sv */
`timescale 1ns/1ps
// interrupt pin pulse generator: turns event requests into fixed low pulses
module int_pulse_gen import mask_pkg::*; #(
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES,
  parameter int GAP_CYCLES   = INT_GAP_CYCLES
) (
  // clock, reset and enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // request and pin
  input  wire logic request,
  output logic      int_n
);
  pulse_state_t state;
  pulse_state_t next_state;
  logic [15:0]  count;
  logic [15:0]  next_count;
  logic         pending;
  logic         next_pending;

  // pulse and recovery gap; a request during either is remembered, not lost
  always_comb begin
    next_state   = state;
    next_count   = count;
    next_pending = pending | request;
    case (state)
      PULSE_IDLE: begin
        if (request) begin
          next_state   = PULSE_LOW;
          next_count   = 16'(PULSE_CYCLES - 1);
          next_pending = 1'b0;
        end
      end
      PULSE_LOW: begin
        if (count == 16'h0000) begin
          next_state = PULSE_GAP;
          next_count = 16'(GAP_CYCLES - 1);
        end else begin
          next_count = count - 16'h0001;
        end
      end
      PULSE_GAP: begin
        if (count != 16'h0000) begin
          next_count = count - 16'h0001;
        end else if (next_pending) begin
          next_state   = PULSE_LOW;
          next_count   = 16'(PULSE_CYCLES - 1);
          next_pending = 1'b0;
        end else begin
          next_state = PULSE_IDLE;
        end
      end
      default: begin
        next_state   = PULSE_IDLE;
        next_count   = 16'h0000;
        next_pending = 1'b0;
      end
    endcase
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= PULSE_IDLE;
      count   <= 16'h0000;
      pending <= 1'b0;
      int_n   <= 1'b1;
    end else if (ce) begin
      state   <= next_state;
      count   <= next_count;
      pending <= next_pending;
      int_n   <= (next_state != PULSE_LOW); // pulse, not a held level RQ16
    end
  end
endmodule

/* mask_pkg.sv */
// constants for the charger event mask block
package mask_pkg;
  // register offsets
  localparam logic [7:0] THERMAL_OTG_EVENT_MASK_ADDR = 8'h2B;
  localparam logic [7:0] FAULT_EVENT_MASK_LOW_ADDR   = 8'h2C;
  // reset values and unmapped read value
  localparam logic [7:0] THERMAL_OTG_EVENT_MASK_RST  = 8'h00;
  localparam logic [7:0] FAULT_EVENT_MASK_LOW_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;
  // writable bits of the thermistor/otg mask register
  localparam logic [7:0] THERMAL_OTG_WRITABLE        = 8'h1F;
  // field positions, thermistor/otg register
  localparam int OTG_LOW_BATTERY_BIT        = 4;
  localparam int THERMISTOR_COLD_BIT        = 3;
  localparam int THERMISTOR_COOL_BIT        = 2;
  localparam int THERMISTOR_WARM_BIT        = 1;
  localparam int THERMISTOR_HOT_BIT         = 0;
  // field positions, fault register
  localparam int CHARGE_CURRENT_REG_BIT     = 7;
  localparam int INPUT_BUS_OV_BIT           = 6;
  localparam int BATTERY_OV_BIT             = 5;
  localparam int INPUT_BUS_OC_BIT           = 4;
  localparam int BATTERY_OC_BIT             = 3;
  localparam int CONVERTER_OC_BIT           = 2;
  localparam int SECOND_SOURCE_OV_BIT       = 1;
  localparam int FIRST_SOURCE_OV_BIT        = 0;
  // interrupt pulse timing
  localparam int CLK_PERIOD_NS              = 10;
  localparam int INT_PULSE_NS               = 1000;
  localparam int INT_GAP_NS                 = 1000;
  localparam int INT_PULSE_CYCLES = (INT_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (INT_PULSE_NS / CLK_PERIOD_NS);
  localparam int INT_GAP_CYCLES   = (INT_GAP_NS / CLK_PERIOD_NS) < 1 ? 1 : (INT_GAP_NS / CLK_PERIOD_NS);
  // pulse generator states
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_LOW  = 2'b01,
    PULSE_GAP  = 2'b10
  } pulse_state_t;
endpackage

/* mask_pkg_note_unused.sv */
// no further content
